// *** verilog/bki_pkg.sv ***
// How it works
// - Selection zero, the reset default, puts the brake signal on no terminal.
// - Selection one to six puts the brake signal on that numbered terminal.
// - Functions sharing one terminal drive it with their logical OR.
// - Other functions on the brake terminal are disabled while it carries brake.
// - With zero delay, brake engages together with servo-on going inactive.
// - Power removal follows brake engagement by 0 to 500 units of 10 ms.
// - An alarm removes motor power at once, ignoring the delay.
// - Servo-off or alarm while rotating engages brake at or below a speed level.
// - Brake output is active low: low releases, high holds the brake.
package bki_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int BKI_CLK_HZ = 10_000_000;
  localparam int BKI_DELAY_UNIT_MS = 10;
  localparam int BKI_UNIT_CYC = BKI_CLK_HZ / 1000 * BKI_DELAY_UNIT_MS;
  localparam logic [8:0] BKI_DELAY_MAX = 9'h1F4;
  localparam logic [12:0] BKI_SPEED_MAX = 13'h1770;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] BKI_REG_PIN_SEL = 8'h00;
  localparam logic [7:0] BKI_REG_DELAY = 8'h04;
  localparam logic [7:0] BKI_REG_SPEED_LVL = 8'h08;
  localparam logic [7:0] BKI_REG_FUNC_MAP = 8'h0C;
  localparam logic [7:0] BKI_REG_STATUS = 8'h10;

  localparam logic [2:0] BKI_PIN_SEL_RST = 3'h0;
  localparam logic [8:0] BKI_DELAY_RST = 9'h000;
  localparam logic [12:0] BKI_SPEED_LVL_RST = 13'h0064;

  localparam int BKI_NUM_TERM = 6;
  localparam int BKI_NUM_FUNC = 4;
  localparam int BKI_SEL_W = 3;

  // Status word fields
  localparam int BKI_ST_POWER = 0;
  localparam int BKI_ST_HOLD = 1;
  localparam int BKI_ST_TERM = 2;
  localparam int BKI_ST_SON = 8;
  localparam int BKI_ST_DELAYING = 9;
  localparam int BKI_ST_SPINNING = 10;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_DELAY,
    ST_SPIN
  } bki_state_type;

endpackage : bki_pkg

// *** verilog/bki_pin_sync.sv ***
`timescale 1ns/1ps
module bki_pin_sync (
  input logic ref_clk,
  input logic rst,
  input logic pin_in,
  output logic level_out
);

  logic ff1_q, ff2_q, ff3_q, lvl_q;
  logic lvl_d;

  // ********************************
  // Three stages, change on agreement
  // ********************************
  always_comb begin
    lvl_d = lvl_q;
    if (ff2_q == ff3_q) begin
      lvl_d = ff3_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ff1_q <= 1'b0;
      ff2_q <= 1'b0;
      ff3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      ff1_q <= pin_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule : bki_pin_sync

// *** verilog/bki_brake_ctrl.sv ***
`timescale 1ns/1ps
module bki_brake_ctrl
  import bki_pkg::*;
#(
  parameter int UNIT_CYCLES = BKI_UNIT_CYC,
  parameter int NUM_FUNC = BKI_NUM_FUNC
) (
  input logic ref_clk,
  input logic rst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic servo_on_pin,
  input logic alarm_in,
  input logic [12:0] motor_speed,
  input logic [NUM_FUNC-1:0] func_in,
  output logic motor_power,
  output logic brake_release_out,
  output logic [BKI_NUM_TERM-1:0] gen_output
);

  localparam int MAP_W = NUM_FUNC * BKI_SEL_W;

  if (UNIT_CYCLES < 1 || UNIT_CYCLES >= 2 ** 17) begin : g_bad_unit
    $error("UNIT_CYCLES must lie in 1 to 131071");
  end
  if (NUM_FUNC < 1 || NUM_FUNC > 10) begin : g_bad_func
    $error("NUM_FUNC must lie in 1 to 10");
  end

  localparam logic [16:0] UNIT_LAST = 17'(UNIT_CYCLES - 1);

  // ********************************
  // Terminal decode
  // ********************************
  // Codes 0 and 7 select nothing
  function automatic logic [BKI_NUM_TERM-1:0] term_hot(
    input logic [BKI_SEL_W-1:0] sel);
    logic [BKI_NUM_TERM-1:0] hot;
    hot = '0;
    if (sel != 3'h0 && sel <= 3'h6) begin
      hot[sel - 3'h1] = 1'b1;
    end
    return hot;
  endfunction : term_hot

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  logic son_s;

  bki_pin_sync u_son_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(servo_on_pin),
    .level_out(son_s)
  );

  // ********************************
  // Configuration registers
  // ********************************
  logic [2:0] pin_sel_q, pin_sel_d;
  logic [8:0] dly_q, dly_d;
  logic [12:0] lvl_q, lvl_d;
  logic [MAP_W-1:0] map_q, map_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] wval, status;
  logic acc;

  bki_state_type st_q, st_d;
  logic power_q, power_d, hold_q, hold_d;
  logic [16:0] pre_q, pre_d;
  logic [8:0] unit_q, unit_d;
  logic [BKI_NUM_TERM-1:0] term_q, term_d;

  always_comb begin
    acc = wb_cyc_i && wb_stb_i && !ack_q;
    ack_d = acc;
    pin_sel_d = pin_sel_q;
    dly_d = dly_q;
    lvl_d = lvl_q;
    map_d = map_q;
    rdat_d = rdat_q;
    wval = 32'h0000_0000;
    status = 32'h0000_0000;
    status[BKI_ST_POWER] = power_q;
    status[BKI_ST_HOLD] = hold_q;
    status[BKI_ST_TERM +: BKI_NUM_TERM] = term_q;
    status[BKI_ST_SON] = son_s;
    status[BKI_ST_DELAYING] = (st_q == ST_DELAY);
    status[BKI_ST_SPINNING] = (st_q == ST_SPIN);
    if (acc) begin
      rdat_d = 32'h0000_0000;
      unique case (wb_adr_i)
        BKI_REG_PIN_SEL: begin
          wval = merge({29'h0, pin_sel_q}, wb_dat_i, wb_sel_i);
          if (wb_we_i) begin
            pin_sel_d = wval[2:0];
          end
          rdat_d = {29'h0, pin_sel_q};
        end
        BKI_REG_DELAY: begin
          // Stored at once, sampled only at servo-off
          wval = merge({23'h0, dly_q}, wb_dat_i, wb_sel_i);
          if (wb_we_i) begin
            dly_d = (wval[31:9] != 23'h0 || wval[8:0] > BKI_DELAY_MAX) ?
                    BKI_DELAY_MAX : wval[8:0];
          end
          rdat_d = {23'h0, dly_q};
        end
        BKI_REG_SPEED_LVL: begin
          wval = merge({19'h0, lvl_q}, wb_dat_i, wb_sel_i);
          if (wb_we_i) begin
            lvl_d = (wval[31:13] != 19'h0 || wval[12:0] > BKI_SPEED_MAX) ?
                    BKI_SPEED_MAX : wval[12:0];
          end
          rdat_d = {19'h0, lvl_q};
        end
        BKI_REG_FUNC_MAP: begin
          wval = merge(32'(map_q), wb_dat_i, wb_sel_i);
          if (wb_we_i) begin
            map_d = wval[MAP_W-1:0];
          end
          rdat_d = 32'(map_q);
        end
        BKI_REG_STATUS: rdat_d = status;
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_sel_q <= BKI_PIN_SEL_RST;
      dly_q <= BKI_DELAY_RST;
      lvl_q <= BKI_SPEED_LVL_RST;
      map_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      pin_sel_q <= pin_sel_d;
      dly_q <= dly_d;
      lvl_q <= lvl_d;
      map_q <= map_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ********************************
  // Brake and power sequencer
  // ********************************
  // Servo-off acts on the synced level with no extra stage; alarm_in is used unsynced
  always_comb begin
    st_d = st_q;
    power_d = power_q;
    hold_d = hold_q;
    pre_d = pre_q;
    unit_d = unit_q;
    unique case (st_q)
      ST_OFF: begin
        if (son_s && !alarm_in) begin
          st_d = ST_RUN;
          power_d = 1'b1;
          hold_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (alarm_in || !son_s) begin
          power_d = 1'b0;
          if (motor_speed > lvl_q) begin
            st_d = ST_SPIN;
          end else if (alarm_in) begin
            st_d = ST_OFF;
            hold_d = 1'b1;
          end else begin
            hold_d = 1'b1;
            if (dly_q == 9'h000) begin
              st_d = ST_OFF;
            end else begin
              st_d = ST_DELAY;
              power_d = 1'b1;
              unit_d = dly_q;
              pre_d = UNIT_LAST;
            end
          end
        end
      end
      ST_DELAY: begin
        if (alarm_in) begin
          st_d = ST_OFF;
          power_d = 1'b0;
        end else if (pre_q != 17'h00000) begin
          pre_d = pre_q - 17'h00001;
        end else if (unit_q == 9'h001) begin
          st_d = ST_OFF;
          power_d = 1'b0;
        end else begin
          unit_d = unit_q - 9'h001;
          pre_d = UNIT_LAST;
        end
      end
      ST_SPIN: begin
        // Motor coasts unpowered; brake waits for low speed
        if (motor_speed <= lvl_q) begin
          st_d = ST_OFF;
          hold_d = 1'b1;
        end
      end
    endcase
  end

  // ********************************
  // Output terminal mapping
  // ********************************
  always_comb begin
    logic [BKI_NUM_TERM-1:0] fh;
    fh = '0;
    term_d = term_hot(pin_sel_q) & {BKI_NUM_TERM{hold_d}};
    for (int i = 0; i < NUM_FUNC; i++) begin
      fh = term_hot(map_q[i*BKI_SEL_W +: BKI_SEL_W]);
      if ((fh & term_hot(pin_sel_q)) == '0) begin
        term_d = term_d | (fh & {BKI_NUM_TERM{func_in[i]}});
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_OFF;
      power_q <= 1'b0;
      hold_q <= 1'b1;
      pre_q <= 17'h00000;
      unit_q <= 9'h000;
      term_q <= '0;
    end else begin
      st_q <= st_d;
      power_q <= power_d;
      hold_q <= hold_d;
      pre_q <= pre_d;
      unit_q <= unit_d;
      term_q <= term_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign motor_power = power_q;
  assign brake_release_out = hold_q;
  assign gen_output = term_q;

  // ********************************
  // Checks
  // ********************************
  property p_no_term;
    @(posedge ref_clk) disable iff (rst)
      (pin_sel_q == 3'h0 && func_in == '0) |=> (gen_output == '0);
  endproperty
  a_no_term: assert property (p_no_term)
    else $error("brake reached a terminal with selection zero");

  property p_route;
    @(posedge ref_clk) disable iff (rst)
      (pin_sel_q != 3'h0 && pin_sel_q <= 3'h6 && $stable(pin_sel_q))
        |-> gen_output[3'(pin_sel_q - 3'h1)] == brake_release_out;
  endproperty
  a_route: assert property (p_route)
    else $error("selected terminal does not follow the brake signal");

  property p_or_func;
    @(posedge ref_clk) disable iff (rst)
      (func_in[0] && map_q[2:0] != 3'h0 && map_q[2:0] <= 3'h6
       && map_q[2:0] != pin_sel_q)
        |=> gen_output[3'($past(map_q[2:0]) - 3'h1)];
  endproperty
  a_or_func: assert property (p_or_func)
    else $error("active function missing from its terminal");

  property p_shared_off;
    @(posedge ref_clk) disable iff (rst)
      (pin_sel_q != 3'h0 && pin_sel_q <= 3'h6 && map_q[2:0] == pin_sel_q
       && func_in[0] && !hold_d) |=> !gen_output[3'($past(pin_sel_q) - 3'h1)];
  endproperty
  a_shared_off: assert property (p_shared_off)
    else $error("function leaked onto the brake terminal");

  sequence s_plain_off;
    st_q == ST_RUN && !son_s && !alarm_in && motor_speed <= lvl_q;
  endsequence

  property p_zero_delay;
    @(posedge ref_clk) disable iff (rst)
      (s_plain_off and dly_q == 9'h000) |=> (brake_release_out && !motor_power);
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("brake not engaged with servo-off");

  property p_delay_load;
    @(posedge ref_clk) disable iff (rst)
      (s_plain_off and dly_q != 9'h000)
        |=> (st_q == ST_DELAY && unit_q == $past(dly_q) && pre_q == UNIT_LAST);
  endproperty
  a_delay_load: assert property (p_delay_load)
    else $error("delay count not loaded from setting");

  property p_alarm_cut;
    @(posedge ref_clk) disable iff (rst)
      (alarm_in && motor_power) |=> !motor_power;
  endproperty
  a_alarm_cut: assert property (p_alarm_cut)
    else $error("power held after alarm");

  property p_spin;
    @(posedge ref_clk) disable iff (rst)
      (st_q == ST_SPIN && motor_speed <= lvl_q) |=> brake_release_out;
  endproperty
  a_spin: assert property (p_spin)
    else $error("rotating stop sequence wrong");

  property p_spin_coast;
    @(posedge ref_clk) disable iff (rst)
      (st_q == ST_SPIN) |-> (!motor_power && !brake_release_out);
  endproperty
  a_spin_coast: assert property (p_spin_coast)
    else $error("motor powered or braked while coasting");

  property p_run_released;
    @(posedge ref_clk) disable iff (rst)
      (st_q == ST_RUN) |-> (!brake_release_out && motor_power);
  endproperty
  a_run_released: assert property (p_run_released)
    else $error("brake output not low while running");

  property p_delay_power;
    @(posedge ref_clk) disable iff (rst)
      (st_q == ST_DELAY && !alarm_in && pre_q == 17'h00000 && unit_q == 9'h001)
        |-> motor_power && brake_release_out ##1 !motor_power;
  endproperty
  a_delay_power: assert property (p_delay_power)
    else $error("power not removed at delay expiry");

  property p_hold_count;
    @(posedge ref_clk) disable iff (rst)
      (st_q == ST_DELAY && !alarm_in && pre_q != 17'h00000)
        |=> (unit_q == $past(unit_q));
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("running delay changed mid-count");

endmodule : bki_brake_ctrl

// *** sim/bki_relay_model.sv ***
`timescale 1ns/1ps
module bki_relay_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] terms,
  input wire logic [2:0] sel,
  output logic freed
);
  // ************************
  // Relay coil
  // ************************
  logic coil;
  logic freed_q;
  logic freed_d;

  // Low terminal level pulls the relay in and frees the brake
  always_comb begin
    coil = 1'b0;
    if (sel >= 3'h1 && sel <= 3'h6) begin
      coil = !terms[sel - 3'h1];
    end
    freed_d = coil;
  end

  // Contacts lag the coil by one cycle, like a slow mechanical relay
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      freed_q <= 1'b0;
    end else begin
      freed_q <= freed_d;
    end
  end

  assign freed = freed_q;
endmodule : bki_relay_model

// *** sim/brake_interlock_output_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
  $time, (g), (e)); end end
module brake_interlock_output_test;
  import bki_pkg::*;
  localparam int U = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd, lf = 32'h0001146F;
  logic son = 1'b0, alm = 1'b0, pwr, brk, freed;
  logic [12:0] spd = 13'h0000;
  logic [3:0] fin = 4'h0;
  logic [5:0] gout;
  logic [2:0] psel = 3'h0;
  logic [11:0] fmap;
  logic [31:0] st_exp;
  int error_cnt = 0;
  int samples_checked = 0;

  always #50 ref_clk = ~ref_clk;

  bki_brake_ctrl #(.UNIT_CYCLES(U)) dut (.ref_clk(ref_clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .servo_on_pin(son), .alarm_in(alm), .motor_speed(spd),
    .func_in(fin), .motor_power(pwr), .brake_release_out(brk),
    .gen_output(gout));

  bki_relay_model relay (.ref_clk(ref_clk), .rst(rst), .terms(gout),
    .sel(psel), .freed(freed));

  // ************************
  // Reference model
  // ************************
  function automatic logic [5:0] exp_term(input logic [2:0] ps,
    input logic [11:0] m, input logic [3:0] f, input logic b);
    logic [5:0] t;
    t = 6'h00;
    for (int k = 0; k < 6; k++) begin
      if (ps == 3'(k + 1)) t[k] = b;
      for (int i = 0; i < 4; i++) begin
        if (m[3*i +: 3] == 3'(k + 1) && ps != 3'(k + 1)) t[k] |= f[i];
      end
    end
    return t;
  endfunction : exp_term

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // ************************
  // Tasks
  // ************************
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Bus cycle: no fixed latency assumed, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = rdat;
    if (t >= 50) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : edges

  task automatic term_sweep(input logic b);
    for (int j = 0; j < 16; j++) begin
      lf = lfsr(lf);
      psel <= 3'(j);
      fmap = lf[11:0];
      fin <= lf[15:12];
      wb(1'b1, BKI_REG_PIN_SEL, 32'(3'(j)));
      wb(1'b1, BKI_REG_FUNC_MAP, 32'(fmap));
      edges(3);
      `CHK(brk, b)
      `CHK(gout, exp_term(psel, fmap, fin, b))
      `CHK(freed, psel >= 3'h1 && psel <= 3'h6 && !b)
    end
  endtask : term_sweep

  // Servo off, then time brake engagement against power removal
  task automatic stop_chk(input int d);
    int t;
    t = 0;
    son <= 1'b0;
    while (brk !== 1'b1 && t < 20) begin
      @(posedge ref_clk);
      t++;
    end
    `CHK(pwr, 1'(d != 0))
    t = 0;
    while (pwr === 1'b1 && t < 3000) begin
      @(posedge ref_clk);
      t++;
    end
    `CHK(t >= d * U && t <= d * U + 1, 1'b1)
  endtask : stop_chk

  task automatic run;
    son <= 1'b1;
    edges(8);
  endtask : run

  // ************************
  // Main sequence
  // ************************
  initial begin
    edges(20);
    rst <= 1'b0;
    edges(1);
    `CHK(gout, 6'h00)
    `CHK(brk, 1'b1)
    wb(1'b0, BKI_REG_PIN_SEL, 32'h0);
    `CHK(rd[2:0], BKI_PIN_SEL_RST)
    wb(1'b0, BKI_REG_DELAY, 32'h0);
    `CHK(rd[8:0], 9'h000)
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    wb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, BKI_REG_DELAY, 32'h00000258);
    wb(1'b0, BKI_REG_DELAY, 32'h0);
    `CHK(rd[8:0], 9'h1F4)
    wb(1'b1, BKI_REG_DELAY, 32'h0);
    wb(1'b0, BKI_REG_SPEED_LVL, 32'h0);
    `CHK(rd[12:0], BKI_SPEED_LVL_RST)
    wb(1'b1, BKI_REG_SPEED_LVL, 32'h00001F40);
    wb(1'b0, BKI_REG_SPEED_LVL, 32'h0);
    `CHK(rd[12:0], BKI_SPEED_MAX)
    // Level 150 so the stop test exercises a programmed threshold
    wb(1'b1, BKI_REG_SPEED_LVL, 32'h00000096);
    run();
    `CHK({pwr, brk}, 2'h2)
    term_sweep(1'b0);
    stop_chk(0);
    term_sweep(1'b1);
    // Delay rewritten mid-wait must not touch the running count
    wb(1'b1, BKI_REG_DELAY, 32'h2);
    run();
    fork
      stop_chk(2);
      begin
        edges(8);
        wb(1'b1, BKI_REG_DELAY, 32'h5);
      end
    join
    run();
    stop_chk(5);
    run();
    alm <= 1'b1;
    edges(2);
    `CHK({pwr, brk}, 2'h1)
    alm <= 1'b0;
    edges(4);
    `CHK(pwr, 1'b1)
    son <= 1'b0;
    edges(8);
    `CHK(pwr, 1'b1)
    wb(1'b0, BKI_REG_STATUS, 32'h0);
    `CHK(rd[BKI_ST_DELAYING], 1'b1)
    `CHK(rd[1:0], 2'h3)
    alm <= 1'b1;
    edges(2);
    `CHK(pwr, 1'b0)
    alm <= 1'b0;
    spd <= 13'h00C8;
    run();
    son <= 1'b0;
    edges(8);
    `CHK({pwr, brk}, 2'h0)
    spd <= 13'h0096;
    edges(3);
    `CHK(brk, 1'b1)
    st_exp = 32'h0000_0000;
    st_exp[BKI_ST_HOLD] = 1'b1;
    st_exp[BKI_ST_TERM +: 6] = exp_term(psel, fmap, fin, 1'b1);
    wb(1'b0, BKI_REG_STATUS, 32'h0);
    `CHK(rd, st_exp)
    // Reset after the rotating stop, servo off, must restore outputs and settings
    rst <= 1'b1;
    edges(2);
    rst <= 1'b0;
    edges(1);
    `CHK({pwr, brk}, 2'h1)
    `CHK(gout, 6'h00)
    wb(1'b0, BKI_REG_PIN_SEL, 32'h0);
    `CHK(rd[2:0], BKI_PIN_SEL_RST)
    wb(1'b0, BKI_REG_SPEED_LVL, 32'h0);
    `CHK(rd[12:0], BKI_SPEED_LVL_RST)
    results();
  end

  initial begin
    #2000000;
    error_cnt++;
    results();
  end
endmodule : brake_interlock_output_test
